// *** hw/itp_timer.sv ***
// Three-channel programmable interval timer with 8-bit host port
`timescale 1ns/100ps
`include "itp_params.svh"
module itp_timer (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic [1:0] i_port_sel,
	input wire logic [7:0] i_data,
	output logic [7:0] o_data,
	output logic o_data_oe,
	input wire logic [`ITP_NCH-1:0] i_cnt_clk,
	input wire logic [`ITP_NCH-1:0] i_gate,
	output logic [`ITP_NCH-1:0] o_out
);
	import itp_pkg::*;

	localparam int HW = $bits(itp_host_t); // Host bits through the synchroniser
	localparam int SW = HW + 2 * `ITP_NCH; // Plus counter clocks and gates

	logic [SW-1:0] raw_pins; // Pins, strobes turned active high
	logic [SW-1:0] pin_lvl; // Filtered pin levels
	itp_host_t host; // Host port now
	itp_host_t host_q; // Host port one cycle ago
	logic [`ITP_NCH-1:0] ck; // Counter clock levels
	logic [`ITP_NCH-1:0] ck_q;
	logic [`ITP_NCH-1:0] gt; // Gate levels
	logic [`ITP_NCH-1:0] gt_q;
	logic [`ITP_NCH-1:0] ck_rise;
	logic [`ITP_NCH-1:0] ck_fall;
	logic [`ITP_NCH-1:0] gt_rise;
	logic wr_end; // Write strobe just released
	logic rd_end; // Read strobe just released
	logic wr_ctrl; // Write to the control word address
	logic rd_act; // Read of a counter in progress
	itp_ctrl_t cw; // Byte being written, seen as a control word
	logic [7:0] rd_byte [`ITP_NCH+1]; // Byte each counter would return

	// Shared address decode for loads, reads and control words
	function automatic logic sel_hit(input logic [1:0] sel, input int idx);
		return sel == 2'(idx);
	endfunction

	////////////////////////////////////////////////////////////////
	// Pin synchronisation; strobes inverted so reset reads as idle
	assign raw_pins = {~i_cs_n, ~i_rd_n, ~i_wr_n, i_port_sel, i_data, i_cnt_clk, i_gate};

	itp_sync #(
		.W(SW)
	) u_sync (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_async(raw_pins),
		.o_level(pin_lvl)
	);

	assign host = itp_host_t'(pin_lvl[SW-1 -: HW]);
	assign ck = pin_lvl[2*`ITP_NCH-1 -: `ITP_NCH];
	assign gt = pin_lvl[`ITP_NCH-1:0];

	// Previous levels for edge detection
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			host_q <= '0;
			ck_q <= '0;
			gt_q <= '0;
		end else begin
			host_q <= host;
			ck_q <= ck;
			gt_q <= gt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Edge and strobe decode
	assign ck_rise = ck & ~ck_q;
	assign ck_fall = ~ck & ck_q;
	assign gt_rise = gt & ~gt_q;
	// Acting on strobe release gives the data its full setup time
	assign wr_end = host_q.cs & host_q.wr & ~host.wr;
	assign rd_end = host_q.cs & host_q.rd & ~host.rd;
	assign cw = itp_ctrl_t'(host_q.data);
	assign wr_ctrl = wr_end & (host_q.sel == `ITP_SEL_CTRL);
	// No driver at the control address, so it never reads back
	assign rd_act = host.cs & host.rd & (host.sel != `ITP_SEL_CTRL);
	assign o_data_oe = rd_act;
	assign rd_byte[`ITP_NCH] = `ITP_BYTE_ZERO;

	// Read data register follows the selected counter while reading
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			o_data <= `ITP_BYTE_ZERO;
		end else if (rd_act) begin
			o_data <= rd_byte[host.sel];
		end
	end

	////////////////////////////////////////////////////////////////
	// Counter channels
	for (genvar i = 0; i < `ITP_NCH; i++) begin : g_ch
		itp_ctrl_t ctl; // Stored control word of this channel
		itp_mode_t mode; // Decoded counting mode
		itp_load_t stage; // Written count on its way to the element
		logic [15:0] init; // Count register as written
		logic [15:0] ce; // Counting element
		logic [15:0] ol; // Latched count for reading
		logic [15:0] nxt; // Element minus this edge's step
		logic [15:0] src; // Value the read port shows
		logic [1:0] step;
		logic wtog; // Low byte written, high byte due
		logic rtog; // Low byte read, high byte due
		logic latched; // Latch holds a value not yet read out
		logic armed; // A count has been loaded since mode set
		logic hold; // Mode 0 halted between two count bytes
		logic active; // One-shot or strobe still running
		logic first; // First edge after a square-wave reload
		logic trig; // Gate rise waiting for a counting edge
		logic out;
		logic cf;
		logic cr;
		logic g;
		logic lde; // Count moves into the element on this edge
		logic tc; // Terminal count on this edge
		logic wr_me;
		logic rd_me;
		logic cw_me;
		logic msb_sel;

		assign mode = itp_mode_of(ctl.mode);
		assign cf = ck_fall[i];
		assign cr = ck_rise[i];
		assign g = gt[i];
		assign wr_me = wr_end & sel_hit(host_q.sel, i);
		assign rd_me = rd_end & sel_hit(host_q.sel, i);
		assign cw_me = wr_ctrl & sel_hit(cw.sel, i);
		assign lde = (stage == ITP_LD_ROSE) & cf;
		assign tc = (nxt == `ITP_CNT_ZERO);
		// Odd square-wave counts take one off high, three off low
		assign step = (mode != ITP_M3) ? `ITP_STEP_1 :
			!(first & init[`ITP_ODD_BIT]) ? `ITP_STEP_2 :
			out ? `ITP_STEP_1 : `ITP_STEP_3;

		itp_decr u_decr (
			.i_value(ce),
			.i_step(step),
			.i_bcd(ctl.bcd),
			.o_diff(nxt)
		);

		// Read port selection; the latch shadows the live count
		assign src = latched ? ol : ce;
		assign msb_sel = (ctl.access == `ITP_RL_MSB) | ((ctl.access == `ITP_RL_BOTH) & rtog);
		assign rd_byte[i] = msb_sel ? src[`ITP_MSB_RANGE] : src[`ITP_LSB_RANGE];
		assign o_out[i] = out;

		// Channel state; later statements take priority
		always_ff @(posedge i_clock) begin
			if (i_sys_rst) begin
				ctl <= '0;
				stage <= ITP_LD_IDLE;
				init <= `ITP_CNT_ZERO;
				ce <= `ITP_CNT_ZERO;
				ol <= `ITP_CNT_ZERO;
				{wtog, rtog, latched, armed, hold, active, first, trig} <= '0;
				out <= 1'b1;
			end else begin
				// A gate rise in the consuming cycle is kept
				trig <= gt_rise[i] | (trig & ~cf);
				// Count waits for a rise and then a fall
				case (stage)
					ITP_LD_WROTE: begin
						if (cr) stage <= ITP_LD_ROSE;
					end
					ITP_LD_ROSE: begin
						if (cf) stage <= ITP_LD_IDLE;
					end
					default: stage <= ITP_LD_IDLE;
				endcase
				// Count byte writes in the programmed order
				if (wr_me) begin
					case (ctl.access)
						`ITP_RL_LSB: begin
							init <= {`ITP_BYTE_ZERO, host_q.data};
							stage <= ITP_LD_WROTE;
						end
						`ITP_RL_MSB: begin
							init <= {host_q.data, `ITP_BYTE_ZERO};
							stage <= ITP_LD_WROTE;
						end
						`ITP_RL_BOTH: begin
							wtog <= ~wtog;
							if (!wtog) begin
								init[`ITP_LSB_RANGE] <= host_q.data;
								hold <= 1'b1;
							end else begin
								init[`ITP_MSB_RANGE] <= host_q.data;
								hold <= 1'b0;
								stage <= ITP_LD_WROTE;
							end
						end
						default: stage <= stage;
					endcase
				end
				// Counting happens on falling counter clock edges
				if (cf) begin
					case (mode)
						ITP_M0: begin
							if (lde) begin
								ce <= init;
								out <= 1'b0;
								armed <= 1'b1;
							end else if (armed & g & ~hold) begin
								// Keeps decrementing past terminal count
								ce <= nxt;
								if (tc) out <= 1'b1;
							end
						end
						ITP_M1: begin
							// Loaded count only arms the next trigger
							if (lde) armed <= 1'b1;
							if (trig & armed) begin
								ce <= init;
								out <= 1'b0;
								active <= 1'b1;
							end else if (active) begin
								ce <= nxt;
								if (tc) begin
									out <= 1'b1;
									active <= 1'b0;
								end
							end
						end
						ITP_M2, ITP_M3: begin
							// A later count waits for the next reload
							if (lde & ~armed) begin
								ce <= init;
								armed <= 1'b1;
								first <= 1'b1;
								out <= 1'b1;
							end else if (trig & armed) begin
								ce <= init;
								first <= 1'b1;
								out <= 1'b1;
							end else if (armed & g & (mode == ITP_M2)) begin
								// Low only while the element holds one
								if (ce == `ITP_CNT_ONE) begin
									ce <= init;
									out <= 1'b1;
								end else begin
									ce <= nxt;
									out <= (nxt != `ITP_CNT_ONE);
								end
							end else if (armed & g) begin
								first <= tc;
								if (tc) begin
									ce <= init;
									out <= ~out;
								end else begin
									ce <= nxt;
								end
							end
						end
						ITP_M4: begin
							if (lde) begin
								ce <= init;
								armed <= 1'b1;
								active <= 1'b1;
								out <= 1'b1;
							end else if (armed & g) begin
								ce <= nxt;
								out <= ~(tc & active);
								if (tc) active <= 1'b0;
							end
						end
						ITP_M5: begin
							if (lde) armed <= 1'b1;
							if (trig & armed) begin
								ce <= init;
								active <= 1'b1;
								out <= 1'b1;
							end else if (armed) begin
								ce <= nxt;
								out <= ~(tc & active);
								if (tc) active <= 1'b0;
							end
						end
						default: out <= 1'b1;
					endcase
				end
				// In modes 2 and 3, gate low forces the output high at once
				if (((mode == ITP_M2) | (mode == ITP_M3)) & ~g) begin
					out <= 1'b1;
				end
				// Read sequencing, low byte then high byte
				if (rd_me) begin
					if (ctl.access == `ITP_RL_BOTH) rtog <= ~rtog;
					if ((ctl.access != `ITP_RL_BOTH) | rtog) latched <= 1'b0;
				end
				// Latch command snapshots the element, mode untouched
				if (cw_me & (cw.access == `ITP_RL_LATCH) & ~latched) begin
					ol <= ce;
					latched <= 1'b1;
				end
				// New control word restarts the channel in its mode
				if (cw_me & (cw.access != `ITP_RL_LATCH)) begin
					ctl <= cw;
					stage <= ITP_LD_IDLE;
					{wtog, rtog, latched, armed, hold, active, first} <= '0;
					out <= (itp_mode_of(cw.mode) != ITP_M0);
				end
			end
		end
	end

endmodule

// *** pkg/itp_params.svh ***
// Named constants shared by the interval timer design files
`ifndef ITP_PARAMS_SVH
`define ITP_PARAMS_SVH

// Number of counter channels
`define ITP_NCH 3

// Port select code of the control word register
`define ITP_SEL_CTRL 2'h3

// Byte access field codes
`define ITP_RL_LATCH 2'h0
`define ITP_RL_LSB 2'h1
`define ITP_RL_MSB 2'h2
`define ITP_RL_BOTH 2'h3

// Decrement step sizes
`define ITP_STEP_1 2'h1
`define ITP_STEP_2 2'h2
`define ITP_STEP_3 2'h3

// Count values and byte lanes
`define ITP_CNT_ZERO 16'h0000
`define ITP_CNT_ONE 16'h0001
`define ITP_BYTE_ZERO 8'h00
`define ITP_MSB_RANGE 15:8
`define ITP_LSB_RANGE 7:0
`define ITP_ODD_BIT 0

// Decimal counting layout
`define ITP_DIGITS 4
`define ITP_DIGIT_W 4
`define ITP_BCD_BASE 5'h0a

`endif

// *** pkg/itp_pkg.sv ***
// Types shared by the interval timer design files
package itp_pkg;

	// Control word layout, bit 7 down to bit 0
	typedef struct packed {
		logic [1:0] sel;
		logic [1:0] access;
		logic [2:0] mode;
		logic bcd;
	} itp_ctrl_t;

	// Host port after synchronisation, strobes active high
	typedef struct packed {
		logic cs;
		logic rd;
		logic wr;
		logic [1:0] sel;
		logic [7:0] data;
	} itp_host_t;

	// Counting modes
	typedef enum logic [2:0] {
		ITP_M0,
		ITP_M1,
		ITP_M2,
		ITP_M3,
		ITP_M4,
		ITP_M5
	} itp_mode_t;

	// Progress of a written count towards the counting element
	typedef enum logic [1:0] {
		ITP_LD_IDLE,
		ITP_LD_WROTE,
		ITP_LD_ROSE
	} itp_load_t;

	// Mode field decode; the top bit is a don't care for modes 2 and 3
	function automatic itp_mode_t itp_mode_of(input logic [2:0] code);
		casez (code)
			3'b000: return ITP_M0;
			3'b001: return ITP_M1;
			3'b?10: return ITP_M2;
			3'b?11: return ITP_M3;
			3'b100: return ITP_M4;
			3'b101: return ITP_M5;
			default: return ITP_M0;
		endcase
	endfunction

endpackage

// *** hw/itp_sync.sv ***
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/100ps
module itp_sync #(
	parameter int W = 1
) (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_level
);

	logic [W-1:0] s1; // Metastable stage, read only by s2
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] agree; // Bits where stages two and three match

	assign agree = s2 ~^ s3;

	////////////////////////////////////////////////////////////////
	// Shift chain; a bit changes only once two stages agree
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			o_level <= '0;
		end else begin
			s1 <= i_async;
			s2 <= s1;
			s3 <= s2;
			o_level <= (agree & s3) | (~agree & o_level);
		end
	end

endmodule

// *** hw/itp_decr.sv ***
// Binary or four-digit decimal subtractor for the counting element
`timescale 1ns/100ps
`include "itp_params.svh"
module itp_decr (
	input wire logic [15:0] i_value,
	input wire logic [1:0] i_step,
	input wire logic i_bcd,
	output logic [15:0] o_diff
);

	logic [15:0] bcd_diff; // Decimal result, wraps 0000 to 9999 region

	////////////////////////////////////////////////////////////////
	// Digit-serial decimal subtract with borrow ripple
	always_comb begin
		logic [4:0] sub;
		logic [4:0] nib;
		logic [4:0] dif;
		sub = {3'h0, i_step};
		nib = 5'h00;
		dif = 5'h00;
		bcd_diff = `ITP_CNT_ZERO;
		for (int d = 0; d < `ITP_DIGITS; d++) begin
			nib = {1'b0, i_value[d*`ITP_DIGIT_W +: `ITP_DIGIT_W]};
			// Borrow from the next digit when this one runs short
			if (nib < sub) begin
				dif = nib + `ITP_BCD_BASE - sub;
				sub = 5'h01;
			end else begin
				dif = nib - sub;
				sub = 5'h00;
			end
			bcd_diff[d*`ITP_DIGIT_W +: `ITP_DIGIT_W] = dif[3:0];
		end
	end

	// Binary wraps naturally, so zero behaves as the largest count
	assign o_diff = i_bcd ? bcd_diff : i_value - 16'(i_step);

endmodule

// *** sim/itp_timer_asserts.sv ***
// Checker for the interval timer host port and counter outputs
`timescale 1ns/100ps
`include "itp_params.svh"
module itp_timer_asserts (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic [1:0] i_port_sel,
	input wire logic [7:0] i_data,
	input wire logic [7:0] o_data,
	input wire logic o_data_oe,
	input wire logic [`ITP_NCH-1:0] i_cnt_clk,
	input wire logic [`ITP_NCH-1:0] i_gate,
	input wire logic [`ITP_NCH-1:0] o_out
);
	import itp_pkg::*;
	////////////////////////////////////////////////////////////////////////////////
	// Pin events that are allowed to move a counter output
	wire [7:0] pin_ev = {i_cnt_clk, i_gate, i_wr_n, i_cs_n};
	// Control word write in progress with a real access code
	wire cw_ok = !i_cs_n && i_port_sel == 2'h3 && i_data[5:4] != 2'h0;
	logic [7:0] pin_ev_q; // Last cycle's pins
	logic [3:0] quiet; // Cycles since a pin event, saturating
	logic [3:0] rd_age; // Cycles a counter read has been held
	// Outputs settle within about five cycles, so twelve leaves margin
	always_ff @(posedge i_clock) begin
		pin_ev_q <= pin_ev;
		quiet <= (i_sys_rst || pin_ev != pin_ev_q) ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
	end
	// Age of a counter read strobe
	always_ff @(posedge i_clock) begin
		rd_age <= (i_sys_rst || i_rd_n || i_cs_n || i_port_sel == 2'h3) ? 4'h0 :
			rd_age + {3'h0, rd_age != 4'hf};
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	ctrl_no_read_a: assert property ((i_port_sel == 2'h3) [*8] |-> !o_data_oe)
		else $error("control port read drove the bus");
	oe_needs_read_a: assert property ($rose(o_data_oe) |-> rd_age inside {[4'h2:4'ha]})
		else $error("read enable rose without a held read");
	oe_release_a: assert property ($rose(i_rd_n) |-> ##[1:8] !o_data_oe)
		else $error("read enable outlived the strobe");
	data_hold_a: assert property (!o_data_oe [*3] |=> $stable(o_data))
		else $error("read data moved while idle");
	out_quiet_a: assert property (quiet >= 4'hc |-> $stable(o_out))
		else $error("counter output moved without an event");
	m0_low_a: assert property ($rose(i_wr_n) && cw_ok && i_data[7:6] == 2'h0 &&
		i_data[3:1] == 3'h0 |-> ##12 !o_out[0])
		else $error("mode 0 set left output high");
	m4_high_a: assert property ($rose(i_wr_n) && cw_ok && i_data[7:6] == 2'h0 &&
		i_data[3:1] == 3'h4 |-> ##12 o_out[0])
		else $error("mode 4 set left output low");
	m2_high_a: assert property ($rose(i_wr_n) && cw_ok && i_data[7:6] == 2'h1 &&
		i_data[2:1] == 2'h2 |-> ##12 o_out[1])
		else $error("mode 2 set left output low");
endmodule
bind itp_timer itp_timer_asserts u_asserts (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
	.i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n), .i_port_sel(i_port_sel),
	.i_data(i_data), .o_data(o_data), .o_data_oe(o_data_oe), .i_cnt_clk(i_cnt_clk),
	.i_gate(i_gate), .o_out(o_out));

// *** sim/itp_host.sv ***
// Host processor model for the timer's parallel port
`timescale 1ns/100ps
module itp_host (
	input wire logic i_clock,
	input wire logic [7:0] i_data,
	input wire logic i_data_oe,
	output logic o_cs_n,
	output logic o_rd_n,
	output logic o_wr_n,
	output logic [1:0] o_port_sel,
	output logic [7:0] o_data
);
	import itp_pkg::*;
	// Idle bus from time zero
	initial begin
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_port_sel = 2'h3;
		o_data = 8'h00;
	end
	// Strobes must outlast the pin synchroniser, so every phase but the read strobe is eight cycles
	task automatic gap();
		repeat (8) @(posedge i_clock);
	endtask
	// One byte write; select, address and data stay until after the strobe ends
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_clock);
		#1;
		o_cs_n = 1'b0;
		o_wr_n = 1'b0;
		o_port_sel = a;
		o_data = d;
		gap();
		#1 o_wr_n = 1'b1;
		gap();
		#1 o_cs_n = 1'b1;
		o_data = ~d; // Released lines must not keep showing the byte
		gap();
	endtask
	// One byte read; ok stays low when the timer never drives the bus
	task automatic rd(input logic [1:0] a, output logic [7:0] v, output bit ok);
		int k;
		ok = 1'b0;
		@(posedge i_clock);
		#1;
		o_cs_n = 1'b0;
		o_rd_n = 1'b0;
		o_port_sel = a;
		// Look just after each edge, once the timer's flops have settled
		for (k = 0; k < 16 && !ok; k++) begin
			@(posedge i_clock);
			#1;
			ok = (i_data_oe === 1'b1);
		end
		repeat (3) @(posedge i_clock);
		#1;
		v = i_data;
		o_rd_n = 1'b1;
		gap();
		#1 o_cs_n = 1'b1;
		gap();
	endtask
endmodule

// *** sim/itp_timer_tb_top.sv ***
// Self-checking bench for the three-channel interval timer
`timescale 1ns/100ps
`include "itp_params.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
	$display("MISMATCH %s exp %h got %h", nm, e, g); n_fail++; end end
module itp_timer_tb_top;
	import itp_pkg::*;
	logic i_clock = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [`ITP_NCH-1:0] cclk = 3'h0; // Counter clocks, idle low
	logic [`ITP_NCH-1:0] gate = 3'h7; // Gates, idle high
	wire cs_n, rd_n, wr_n, oe;
	wire [1:0] sel;
	wire [7:0] host_d, rd_d;
	wire [`ITP_NCH-1:0] o_out;
	int n_fail = 0;
	int n_tests = 0;
	always #5 i_clock = ~i_clock;
	itp_timer uut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_cs_n(cs_n), .i_rd_n(rd_n),
		.i_wr_n(wr_n), .i_port_sel(sel), .i_data(host_d), .o_data(rd_d), .o_data_oe(oe),
		.i_cnt_clk(cclk), .i_gate(gate), .o_out(o_out));
	itp_host u_host (.i_clock(i_clock), .i_data(rd_d), .i_data_oe(oe), .o_cs_n(cs_n),
		.o_rd_n(rd_n), .o_wr_n(wr_n), .o_port_sel(sel), .o_data(host_d));
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Counter clock pulses; each phase is long enough to pass the synchroniser
	task automatic pulse(input int ch, input int n);
		repeat (n) begin
			@(posedge i_clock);
			#1 cclk[ch] = 1'b1;
			repeat (8) @(posedge i_clock);
			#1 cclk[ch] = 1'b0;
			repeat (8) @(posedge i_clock);
		end
	endtask
	// Output level after each pulse, bit k of pat after pulse k+1
	task automatic seq(input int ch, input int n, input logic [7:0] pat);
		for (int k = 0; k < n; k++) begin
			pulse(ch, 1);
			`CHK("out", pat[k], o_out[ch])
		end
	endtask
	task automatic set_gate(input int ch, input logic v);
		@(posedge i_clock);
		#1 gate[ch] = v;
		repeat (10) @(posedge i_clock);
	endtask
	// Counter read; a missing bus answer ends the run
	task automatic rdc(input logic [1:0] a, input logic [7:0] e);
		logic [7:0] v;
		bit ok;
		u_host.rd(a, v, ok);
		if (!ok) begin
			$display("MISMATCH read_enable exp 1 got 0");
			n_fail++;
			end_of_test();
		end
		`CHK("read", e, v)
	endtask
	task automatic wcnt(input logic [1:0] a, input logic [15:0] c);
		u_host.wr(a, c[7:0]);
		u_host.wr(a, c[15:8]);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_mode0();
		logic [7:0] v;
		bit ok;
		u_host.rd(2'h3, v, ok);
		`CHK("ctrl_read", 1'b0, ok)
		u_host.wr(2'h3, 8'h30);
		`CHK("m0_set", 1'b0, o_out[0])
		wcnt(2'h0, 16'h0003);
		seq(0, 1, 8'h00);
		rdc(2'h0, 8'h03);
		rdc(2'h0, 8'h00);
		seq(0, 4, 8'h0c);
		rdc(2'h0, 8'hff);
		rdc(2'h0, 8'hff);
		$display("test mode0 done");
	endtask
	task automatic t_access();
		u_host.wr(2'h3, 8'h20);
		u_host.wr(2'h0, 8'h01);
		pulse(0, 1);
		rdc(2'h0, 8'h01);
		u_host.wr(2'h3, 8'h00);
		pulse(0, 1);
		rdc(2'h0, 8'h01);
		rdc(2'h0, 8'h00);
		u_host.wr(2'h3, 8'h31);
		wcnt(2'h0, 16'h0010);
		pulse(0, 2);
		rdc(2'h0, 8'h09);
		rdc(2'h0, 8'h00);
		u_host.wr(2'h3, 8'h31);
		wcnt(2'h0, 16'h0000);
		pulse(0, 2);
		rdc(2'h0, 8'h99);
		rdc(2'h0, 8'h99);
		$display("test access done");
	endtask
	task automatic t_mode2();
		u_host.wr(2'h3, 8'h7c);
		`CHK("m2_set", 1'b1, o_out[1])
		wcnt(2'h1, 16'h0003);
		seq(1, 6, 8'h1b);
		set_gate(1, 1'b0);
		`CHK("m2_gate", 1'b1, o_out[1])
		seq(1, 2, 8'h03);
		set_gate(1, 1'b1);
		seq(1, 3, 8'h03);
		$display("test mode2 done");
	endtask
	task automatic t_mode34();
		u_host.wr(2'h3, 8'hb6);
		wcnt(2'h2, 16'h0004);
		seq(2, 5, 8'h13);
		u_host.wr(2'h3, 8'hbe);
		wcnt(2'h2, 16'h0005);
		seq(2, 6, 8'h27);
		u_host.wr(2'h3, 8'h18);
		`CHK("m4_set", 1'b1, o_out[0])
		u_host.wr(2'h0, 8'h02);
		seq(0, 5, 8'h1b);
		set_gate(0, 1'b0);
		u_host.wr(2'h0, 8'h02);
		seq(0, 4, 8'h0f);
		rdc(2'h0, 8'h02);
		set_gate(0, 1'b1);
		seq(0, 2, 8'h01);
		$display("test mode3 mode4 done");
	endtask
	// Gate-triggered modes: arm with a count, then fire with a gate rise
	task automatic t_trig(input int ch, input logic [7:0] cw, input logic [7:0] c,
		input logic [7:0] pat);
		u_host.wr(2'h3, cw);
		u_host.wr(2'(ch), c);
		pulse(ch, 1);
		`CHK("armed", 1'b1, o_out[ch])
		set_gate(ch, 1'b0);
		set_gate(ch, 1'b1);
		seq(ch, 4, pat);
		// Trigger, one edge, then a second trigger mid-count
		set_gate(ch, 1'b0);
		set_gate(ch, 1'b1);
		seq(ch, 1, pat);
		set_gate(ch, 1'b0);
		set_gate(ch, 1'b1);
		seq(ch, 4, pat);
		$display("test trigger done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge i_clock);
		#1 i_sys_rst = 1'b0;
		repeat (8) @(posedge i_clock);
		t_mode0();
		t_access();
		t_mode2();
		t_mode34();
		t_trig(1, 8'h5a, 8'h02, 8'h0b);
		t_trig(2, 8'h92, 8'h03, 8'h08);
		end_of_test();
	end
endmodule
